// file: hdl/sami_pkg.sv
package sami_pkg;
	// ----------------------------------------------------------------
	// Link framing
	// ----------------------------------------------------------------
	localparam int ADDR_W       = 3;
	localparam int CMD_BITS     = 4;
	localparam int RES_W        = 10;
	localparam int PAD_BITS     = 6;
	localparam int FRAME_BITS   = 16;
	// Sampling of 4.5 link periods ends on the fifth falling edge
	localparam int SAMPLE_FALLS = 5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CONV_CYCLES   = 41;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SETUP_NS      = 100;
	localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_HALF     = 2;

	// ----------------------------------------------------------------
	// Reset values and SAR top bit
	// ----------------------------------------------------------------
	localparam logic [FRAME_BITS-1:0] SREG_RST = 16'h0000;
	localparam logic [RES_W-1:0]      RES_RST  = 10'h000;
	localparam logic [RES_W-1:0]      SAR_TOP  = 10'h200;
endpackage

// file: hdl/sami_if.sv
`timescale 1ns/10ps
interface sami_if;
	logic sclk;
	logic cs_n;
	logic oe_n;
	logic din;
	logic dout;
	logic dout_oe;
	logic status;
	logic dout_line;

	// Undriven data line reads low, as through a weak pull-down
	assign dout_line = dout_oe & dout;

	modport dev (
		input  sclk,
		input  cs_n,
		input  oe_n,
		input  din,
		output dout,
		output dout_oe,
		output status
	);

	modport host (
		output sclk,
		output cs_n,
		output oe_n,
		output din,
		input  dout_line,
		input  status
	);
endinterface

// file: hdl/sami_dev.sv
`timescale 1ns/10ps
module sami_dev #(
	parameter int CHANNELS = 8
) (
	// Conversion clock and reset
	input  wire logic                                 ref_clk,
	input  wire logic                                 reset,
	// Serial link, clocked by the host
	sami_if.dev                                       link,
	// Digitised level of each analog input
	input  wire logic [7:0][sami_pkg::RES_W-1:0]      analog_input
);
	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	function automatic logic [2:0] chan_sel(input logic [2:0] addr);
		if (CHANNELS == 8)
			chan_sel = addr;
		else if (CHANNELS == 4)
			chan_sel = {1'b0, addr[1:0]};
		else
			chan_sel = 3'h0;
	endfunction

	function automatic logic [4:0] frame_len(input logic right);
		frame_len = right ? 5'(sami_pkg::FRAME_BITS) : 5'(sami_pkg::RES_W);
	endfunction

	// ----------------------------------------------------------------
	// Link rising edge: address and format capture
	// ----------------------------------------------------------------
	logic [2:0] addr_reg;
	logic [2:0] addr_next;
	logic       fmt_reg;
	logic       fmt_next;
	logic [2:0] bit_cnt_reg;
	logic [2:0] bit_cnt_next;

	always_comb begin
		addr_next    = addr_reg;
		fmt_next     = fmt_reg;
		bit_cnt_next = bit_cnt_reg;
		if (link.cs_n) begin
			bit_cnt_next = 3'h0;
		end else if (bit_cnt_reg < 3'(sami_pkg::CMD_BITS)) begin
			bit_cnt_next = bit_cnt_reg + 3'h1;
			if (bit_cnt_reg < 3'(sami_pkg::ADDR_W))
				addr_next = {addr_reg[1:0], link.din};
			else
				fmt_next = (CHANNELS == 1) ? 1'b0 : link.din;
		end
	end

	always_ff @(posedge link.sclk or posedge reset) begin
		if (reset) begin
			addr_reg    <= 3'h0;
			fmt_reg     <= 1'b0;
			bit_cnt_reg <= 3'h0;
		end else begin
			addr_reg    <= addr_next;
			fmt_reg     <= fmt_next;
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// Link falling edge: sampling window and output shifting
	// ----------------------------------------------------------------
	logic [2:0]                      samp_cnt_reg;
	logic [2:0]                      samp_cnt_next;
	logic                            started_reg;
	logic                            started_next;
	logic                            start_tgl_reg;
	logic                            start_tgl_next;
	logic [sami_pkg::FRAME_BITS-1:0] sreg_reg;
	logic [sami_pkg::FRAME_BITS-1:0] sreg_next;
	logic [4:0]                      out_cnt_reg;
	logic [4:0]                      out_cnt_next;
	logic                            out_fmt_reg;
	logic                            out_fmt_next;
	logic                            dout_reg;
	logic                            dout_next;
	logic                            oe_reg;
	logic                            oe_next;
	logic                            seen_reg;
	logic                            seen_next;
	logic                            done_s1_reg;
	logic                            done_s2_reg;
	logic                            done_tgl_reg;
	logic [sami_pkg::RES_W-1:0]      res_reg;
	logic                            res_fmt_reg;

	always_comb begin
		samp_cnt_next  = samp_cnt_reg;
		started_next   = started_reg;
		start_tgl_next = start_tgl_reg;
		sreg_next      = sreg_reg;
		out_cnt_next   = out_cnt_reg;
		out_fmt_next   = out_fmt_reg;
		dout_next      = dout_reg;
		seen_next      = seen_reg;
		oe_next        = !link.cs_n && (CHANNELS == 1 || !link.oe_n);
		if (link.cs_n) begin
			samp_cnt_next = 3'h0;
			started_next  = 1'b0;
			out_cnt_next  = 5'h00;
		end else if (bit_cnt_reg == 3'(sami_pkg::CMD_BITS) && !started_reg) begin
			samp_cnt_next = samp_cnt_reg + 3'h1;
			if (samp_cnt_reg == 3'(sami_pkg::SAMPLE_FALLS - 1)) begin
				started_next   = 1'b1;
				start_tgl_next = ~start_tgl_reg;
			end
		end
		// A fresh result takes this edge; the shift waits one period
		if (done_s2_reg != seen_reg) begin
			seen_next    = done_s2_reg;
			out_fmt_next = res_fmt_reg;
			if (!link.cs_n && out_cnt_reg < frame_len(out_fmt_reg))
				sreg_next = sami_pkg::SREG_RST;
			else if (res_fmt_reg)
				sreg_next = {{sami_pkg::PAD_BITS{1'b0}}, res_reg};
			else
				sreg_next = {res_reg, {sami_pkg::PAD_BITS{1'b0}}};
		end else if (oe_next) begin
			dout_next = sreg_reg[sami_pkg::FRAME_BITS-1];
			sreg_next = {sreg_reg[sami_pkg::FRAME_BITS-2:0], 1'b0};
			if (out_cnt_reg != 5'h1F)
				out_cnt_next = out_cnt_reg + 5'h01;
		end
	end

	// Power-up content is arbitrary in silicon; cleared here for determinism
	always_ff @(negedge link.sclk or posedge reset) begin
		if (reset) begin
			samp_cnt_reg  <= 3'h0;
			started_reg   <= 1'b0;
			start_tgl_reg <= 1'b0;
			sreg_reg      <= sami_pkg::SREG_RST;
			out_cnt_reg   <= 5'h00;
			out_fmt_reg   <= 1'b0;
			dout_reg      <= 1'b0;
			oe_reg        <= 1'b0;
			seen_reg      <= 1'b0;
			done_s1_reg   <= 1'b0;
			done_s2_reg   <= 1'b0;
		end else begin
			samp_cnt_reg  <= samp_cnt_next;
			started_reg   <= started_next;
			start_tgl_reg <= start_tgl_next;
			sreg_reg      <= sreg_next;
			out_cnt_reg   <= out_cnt_next;
			out_fmt_reg   <= out_fmt_next;
			dout_reg      <= dout_next;
			oe_reg        <= oe_next;
			seen_reg      <= seen_next;
			done_s1_reg   <= done_tgl_reg;
			done_s2_reg   <= done_s1_reg;
		end
	end

	assign link.dout    = dout_reg;
	assign link.dout_oe = oe_reg;

	// ----------------------------------------------------------------
	// Conversion clock domain: approximation and status
	// ----------------------------------------------------------------
	// Free-running ref_clk serves as the conversion clock
	logic                       st_s1_reg;
	logic                       st_s2_reg;
	logic                       st_s3_reg;
	logic                       status_reg;
	logic                       status_next;
	logic [5:0]                 cnt_reg;
	logic [5:0]                 cnt_next;
	logic [sami_pkg::RES_W-1:0] sample_reg;
	logic [sami_pkg::RES_W-1:0] sample_next;
	logic [sami_pkg::RES_W-1:0] sar_reg;
	logic [sami_pkg::RES_W-1:0] sar_next;
	logic [sami_pkg::RES_W-1:0] trial;
	logic [sami_pkg::RES_W-1:0] res_next;
	logic                       res_fmt_next;
	logic                       cfmt_reg;
	logic                       cfmt_next;
	logic                       done_tgl_next;

	always_comb begin
		status_next   = status_reg;
		cnt_next      = cnt_reg;
		sample_next   = sample_reg;
		sar_next      = sar_reg;
		res_next      = res_reg;
		res_fmt_next  = res_fmt_reg;
		cfmt_next     = cfmt_reg;
		done_tgl_next = done_tgl_reg;
		trial         = sar_reg | (sami_pkg::SAR_TOP >> cnt_reg);
		if (!status_reg) begin
			// Address and format are static once the window closes
			if (st_s2_reg != st_s3_reg) begin
				sample_next = analog_input[chan_sel(addr_reg)];
				sar_next    = sami_pkg::RES_RST;
				cnt_next    = 6'h00;
				cfmt_next   = fmt_reg;
				status_next = 1'b1;
			end
		end else begin
			if (cnt_reg < 6'(sami_pkg::RES_W) && trial <= sample_reg)
				sar_next = trial;
			cnt_next = cnt_reg + 6'h01;
			if (cnt_reg == 6'(sami_pkg::CONV_CYCLES - 1)) begin
				status_next   = 1'b0;
				res_next      = sar_reg;
				res_fmt_next  = cfmt_reg;
				done_tgl_next = ~done_tgl_reg;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_s1_reg    <= 1'b0;
			st_s2_reg    <= 1'b0;
			st_s3_reg    <= 1'b0;
			status_reg   <= 1'b0;
			cnt_reg      <= 6'h00;
			sample_reg   <= sami_pkg::RES_RST;
			sar_reg      <= sami_pkg::RES_RST;
			res_reg      <= sami_pkg::RES_RST;
			res_fmt_reg  <= 1'b0;
			cfmt_reg     <= 1'b0;
			done_tgl_reg <= 1'b0;
		end else begin
			st_s1_reg    <= start_tgl_reg;
			st_s2_reg    <= st_s1_reg;
			st_s3_reg    <= st_s2_reg;
			status_reg   <= status_next;
			cnt_reg      <= cnt_next;
			sample_reg   <= sample_next;
			sar_reg      <= sar_next;
			res_reg      <= res_next;
			res_fmt_reg  <= res_fmt_next;
			cfmt_reg     <= cfmt_next;
			done_tgl_reg <= done_tgl_next;
		end
	end

	assign link.status = status_reg;
endmodule

// file: hdl/sami_host.sv
`timescale 1ns/10ps
module sami_host #(
	parameter int HALF = sami_pkg::SCLK_HALF
) (
	// Clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          reset,
	// Request
	input  wire logic                          req,
	input  wire logic [sami_pkg::ADDR_W-1:0]   req_chan,
	input  wire logic                          req_right,
	output logic                               busy,
	// Answer
	output logic                               rd_valid,
	output logic [sami_pkg::RES_W-1:0]         rd_data,
	output logic                               rd_right,
	output logic                               conv_status,
	// Serial link
	sami_if.host                               link
);
	typedef enum logic [1:0] {IDLE, SETUP, XFER} sami_hst_t;

	function automatic logic cmd_bit(input logic [4:0] idx,
		input logic [2:0] chan, input logic right);
		case (idx)
			5'h00:   cmd_bit = chan[2];
			5'h01:   cmd_bit = chan[1];
			5'h02:   cmd_bit = chan[0];
			5'h03:   cmd_bit = right;
			default: cmd_bit = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sami_hst_t                       st_reg, st_next;
	logic [3:0]                      div_reg, div_next;
	logic                            sclk_reg, sclk_next;
	logic                            cs_n_reg, cs_n_next;
	logic                            din_reg, din_next;
	logic                            pend_reg, pend_next;
	logic [2:0]                      chan_reg, chan_next;
	logic                            fmt_reg, fmt_next;
	logic                            prev_fmt_reg, prev_fmt_next;
	logic                            primed_reg, primed_next;
	logic [4:0]                      wait_reg, wait_next;
	logic [4:0]                      rise_reg, rise_next;
	logic [4:0]                      fall_reg, fall_next;
	logic [4:0]                      cap_cnt_reg, cap_cnt_next;
	logic [sami_pkg::FRAME_BITS-1:0] cap_reg, cap_next;
	logic                            valid_next;
	logic [sami_pkg::RES_W-1:0]      data_next;
	logic                            right_next;
	logic                            dout_s1_reg, dout_s2_reg;
	logic                            stat_s1_reg;
	logic                            run, tick, rise, fall, mid;

	always_comb begin
		run  = st_reg != SETUP;
		tick = div_reg == 4'(HALF - 1);
		rise = run && tick && !sclk_reg;
		fall = run && tick && sclk_reg;
		mid  = run && div_reg == 4'h0 && !tick;
		div_next      = run ? (tick ? 4'h0 : div_reg + 4'h1) : div_reg;
		sclk_next     = (run && tick) ? ~sclk_reg : sclk_reg;
		st_next       = st_reg;
		cs_n_next     = cs_n_reg;
		din_next      = din_reg;
		pend_next     = pend_reg | (req & !busy);
		chan_next     = chan_reg;
		fmt_next      = fmt_reg;
		prev_fmt_next = prev_fmt_reg;
		primed_next   = primed_reg;
		wait_next     = wait_reg;
		rise_next     = rise_reg;
		fall_next     = fall_reg;
		cap_cnt_next  = cap_cnt_reg;
		cap_next      = cap_reg;
		valid_next    = 1'b0;
		data_next     = rd_data;
		right_next    = rd_right;
		case (st_reg)
			IDLE: begin
				// Select never moves on an edge that moves the clock
				if (pend_reg && !tick) begin
					pend_next    = 1'b0;
					chan_next    = req_chan;
					fmt_next     = req_right;
					cs_n_next    = 1'b0;
					din_next     = cmd_bit(5'h00, req_chan, req_right);
					wait_next    = 5'h00;
					rise_next    = 5'h00;
					fall_next    = 5'h00;
					cap_cnt_next = 5'h00;
					st_next      = SETUP;
				end
			end
			SETUP: begin
				// Link clock held still so select leads the first rise
				wait_next = wait_reg + 5'h01;
				if (wait_reg == 5'(sami_pkg::SETUP_CYC - 1))
					st_next = XFER;
			end
			XFER: begin
				if (rise && rise_reg != 5'h1F)
					rise_next = rise_reg + 5'h01;
				if (fall)
					fall_next = fall_reg + 5'h01;
				if (mid && !sclk_reg)
					din_next = cmd_bit(rise_reg, chan_reg, fmt_reg);
				if (mid && sclk_reg && fall_reg != cap_cnt_reg) begin
					cap_next     = {cap_reg[sami_pkg::FRAME_BITS-2:0], dout_s2_reg};
					cap_cnt_next = cap_cnt_reg + 5'h01;
					if (cap_cnt_reg == 5'(sami_pkg::FRAME_BITS - 1)) begin
						cs_n_next     = 1'b1;
						st_next       = IDLE;
						valid_next    = primed_reg;
						primed_next   = 1'b1;
						right_next    = prev_fmt_reg;
						data_next     = prev_fmt_reg ? cap_next[sami_pkg::RES_W-1:0]
							: cap_next[sami_pkg::FRAME_BITS-1:sami_pkg::PAD_BITS];
						prev_fmt_next = fmt_reg;
					end
				end
			end
			default: st_next = IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_reg       <= IDLE;
			div_reg      <= 4'h0;
			sclk_reg     <= 1'b0;
			cs_n_reg     <= 1'b1;
			din_reg      <= 1'b0;
			pend_reg     <= 1'b0;
			chan_reg     <= 3'h0;
			fmt_reg      <= 1'b0;
			prev_fmt_reg <= 1'b0;
			primed_reg   <= 1'b0;
			wait_reg     <= 5'h00;
			rise_reg     <= 5'h00;
			fall_reg     <= 5'h00;
			cap_cnt_reg  <= 5'h00;
			cap_reg      <= sami_pkg::SREG_RST;
			rd_valid     <= 1'b0;
			rd_data      <= sami_pkg::RES_RST;
			rd_right     <= 1'b0;
			busy         <= 1'b0;
			dout_s1_reg  <= 1'b0;
			dout_s2_reg  <= 1'b0;
			stat_s1_reg  <= 1'b0;
			conv_status  <= 1'b0;
		end else begin
			st_reg       <= st_next;
			div_reg      <= div_next;
			sclk_reg     <= sclk_next;
			cs_n_reg     <= cs_n_next;
			din_reg      <= din_next;
			pend_reg     <= pend_next;
			chan_reg     <= chan_next;
			fmt_reg      <= fmt_next;
			prev_fmt_reg <= prev_fmt_next;
			primed_reg   <= primed_next;
			wait_reg     <= wait_next;
			rise_reg     <= rise_next;
			fall_reg     <= fall_next;
			cap_cnt_reg  <= cap_cnt_next;
			cap_reg      <= cap_next;
			rd_valid     <= valid_next;
			rd_data      <= data_next;
			rd_right     <= right_next;
			busy         <= pend_next || st_next != IDLE;
			dout_s1_reg  <= link.dout_line;
			dout_s2_reg  <= dout_s1_reg;
			stat_s1_reg  <= link.status;
			conv_status  <= stat_s1_reg;
		end
	end

	// Fast link clock keeps each exchange ahead of the conversion
	assign link.sclk = sclk_reg;
	assign link.cs_n = cs_n_reg;
	assign link.oe_n = cs_n_reg;
	assign link.din  = din_reg;
endmodule

// file: dv/sami_props.sv
`timescale 1ns/10ps
module sami_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Link wires
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic status
);
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	logic [7:0] stat_cnt_reg;
	logic [7:0] stat_cnt_next;
	logic [7:0] rise_cnt_reg;
	logic [7:0] rise_cnt_next;
	logic       sclk_d_reg;
	logic       sclk_d_next;

	always_comb begin
		stat_cnt_next = status ? stat_cnt_reg + 8'h01 : 8'h00;
		rise_cnt_next = cs_n ? 8'h00 :
			rise_cnt_reg + {7'h00, sclk & ~sclk_d_reg};
		sclk_d_next   = sclk;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			stat_cnt_reg <= 8'h00;
			rise_cnt_reg <= 8'h00;
			sclk_d_reg   <= 1'b0;
		end else begin
			stat_cnt_reg <= stat_cnt_next;
			rise_cnt_reg <= rise_cnt_next;
			sclk_d_reg   <= sclk_d_next;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_status_width: assert property (
		$fell(status) |-> stat_cnt_reg == sami_pkg::CONV_CYCLES)
		else $error("status high time wrong");
	a_status_max: assert property (
		status |-> stat_cnt_reg < sami_pkg::CONV_CYCLES)
		else $error("status held too long");
	// Range absorbs the divider phase and the start handover
	a_status_start: assert property (
		$rose(status) |-> !cs_n && rise_cnt_reg >= 8 && rise_cnt_reg <= 10)
		else $error("sampling window length wrong");
	a_status_late: assert property (
		$fell(status) |-> cs_n)
		else $error("status fell inside exchange");
	a_dout_on_fall: assert property (
		$changed(dout) || $changed(dout_oe) |-> $fell(sclk))
		else $error("output moved off a falling edge");
	a_din_stable: assert property (
		$rose(sclk) && !cs_n |-> $stable(din))
		else $error("serial input moved at capture");
	a_setup_time: assert property (
		$fell(cs_n) |-> (!$rose(sclk))[*8] ##1 (!$rose(sclk))[*5])
		else $error("select setup too short");
	a_oe_on: assert property (
		$fell(sclk) && !cs_n && !$past(cs_n) && !oe_n && !$past(oe_n)
		|-> dout_oe)
		else $error("output not driven while enabled");
	a_oe_off: assert property (
		$fell(sclk) && cs_n && $past(cs_n) |-> !dout_oe)
		else $error("output driven while deselected");
endmodule

// file: dv/serial_adc_mux_interface_tb.sv
`timescale 1ns/10ps
module serial_adc_mux_interface_tb;
	logic                                 ref_clk;
	logic                                 reset;
	logic                                 req;
	logic [sami_pkg::ADDR_W-1:0]          req_chan;
	logic                                 req_right;
	logic                                 busy;
	logic                                 busy4;
	logic                                 busy1;
	logic                                 rd_valid;
	logic                                 rd_valid4;
	logic                                 rd_valid1;
	logic                                 rd_right;
	logic                                 rd_right4;
	logic                                 rd_right1;
	logic                                 stat;
	logic                                 stat4;
	logic                                 stat1;
	logic [sami_pkg::RES_W-1:0]           rd_data;
	logic [sami_pkg::RES_W-1:0]           rd_data4;
	logic [sami_pkg::RES_W-1:0]           rd_data1;
	logic [7:0][sami_pkg::RES_W-1:0]      analog_input;
	logic [11:0]                          q_rd[$];
	logic [11:0]                          q_rd4[$];
	logic [11:0]                          q_rd1[$];
	logic [16:0]                          q_wire[$];
	logic [15:0]                          wire_sh;
	logic                                 armed;
	logic                                 prev_ok;
	logic [2:0]                           prev_chan;
	logic                                 prev_right;
	int                                   wire_bits;
	int                                   wire_frames;
	int                                   failures;
	int                                   checked;

	// ----------------------------------------------------------------
	// Three pairs: eight, four and one input
	// ----------------------------------------------------------------
	sami_if u_sami_if ();
	sami_if u_sami_if_4 ();
	sami_if u_sami_if_1 ();

	sami_host u_sami_host (.ref_clk(ref_clk), .reset(reset), .req(req),
		.req_chan(req_chan), .req_right(req_right), .busy(busy),
		.rd_valid(rd_valid), .rd_data(rd_data), .rd_right(rd_right),
		.conv_status(stat), .link(u_sami_if));
	sami_dev #(.CHANNELS(8)) u_sami_dev (.ref_clk(ref_clk), .reset(reset),
		.link(u_sami_if), .analog_input(analog_input));
	sami_host u_sami_host_4 (.ref_clk(ref_clk), .reset(reset), .req(req),
		.req_chan(req_chan), .req_right(req_right), .busy(busy4),
		.rd_valid(rd_valid4), .rd_data(rd_data4), .rd_right(rd_right4),
		.conv_status(stat4), .link(u_sami_if_4));
	sami_dev #(.CHANNELS(4)) u_sami_dev_4 (.ref_clk(ref_clk),
		.reset(reset), .link(u_sami_if_4), .analog_input(analog_input));
	sami_host u_sami_host_1 (.ref_clk(ref_clk), .reset(reset), .req(req),
		.req_chan(req_chan), .req_right(req_right), .busy(busy1),
		.rd_valid(rd_valid1), .rd_data(rd_data1), .rd_right(rd_right1),
		.conv_status(stat1), .link(u_sami_if_1));
	sami_dev #(.CHANNELS(1)) u_sami_dev_1 (.ref_clk(ref_clk),
		.reset(reset), .link(u_sami_if_1), .analog_input(analog_input));

	sami_props u_sami_props (.ref_clk(ref_clk), .reset(reset),
		.sclk(u_sami_if.sclk), .cs_n(u_sami_if.cs_n),
		.oe_n(u_sami_if.oe_n), .din(u_sami_if.din),
		.dout(u_sami_if.dout), .dout_oe(u_sami_if.dout_oe),
		.status(u_sami_if.status));

	initial begin
		ref_clk = 1'b0;
		forever #(sami_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Compare and verdict
	// ----------------------------------------------------------------
	task automatic cmp_rd(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t result got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_wire(input logic [16:0] got, input logic [16:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t wire got %h exp %h", $time, got, exp);
		end
	endtask

	task print_verdict;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Monitors
	// ----------------------------------------------------------------
	// Pulse is read mid-cycle; status must still be high at frame end
	always @(negedge ref_clk) begin
		if (rd_valid === 1'b1)
			cmp_rd({stat, rd_right, rd_data}, q_rd.pop_front());
		if (rd_valid4 === 1'b1)
			cmp_rd({stat4, rd_right4, rd_data4}, q_rd4.pop_front());
		if (rd_valid1 === 1'b1)
			cmp_rd({stat1, rd_right1, rd_data1}, q_rd1.pop_front());
	end

	// Bits are taken only at rises that follow a shifting fall
	always @(negedge u_sami_if.sclk) begin
		if (u_sami_if.cs_n === 1'b0)
			armed = 1'b1;
	end

	always @(posedge u_sami_if.sclk) begin
		if (u_sami_if.cs_n === 1'b0 && armed) begin
			wire_sh = {wire_sh[14:0], u_sami_if.dout_line};
			wire_bits++;
		end
	end

	always @(posedge u_sami_if.cs_n) begin
		if (!reset && wire_frames > 0)
			cmp_wire({wire_bits == 16, wire_sh}, q_wire.pop_front());
		if (!reset)
			wire_frames++;
		wire_bits = 0;
		armed = 1'b0;
	end

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	task automatic run_frame(input logic [2:0] chan, input logic right);
		logic [9:0] v;
		int         n;
		@(negedge ref_clk);
		req       = 1'b1;
		req_chan  = chan;
		req_right = right;
		@(negedge ref_clk);
		req = 1'b0;
		if (prev_ok) begin
			v = analog_input[prev_chan];
			q_rd.push_back({1'b1, prev_right, v});
			q_wire.push_back({1'b1, prev_right ? {6'h00, v} : {v, 6'h00}});
			v = analog_input[{1'b0, prev_chan[1:0]}];
			q_rd4.push_back({1'b1, prev_right, v});
			// One input: always left framed, host still slices as asked
			v = analog_input[0];
			q_rd1.push_back({1'b1, prev_right,
				prev_right ? {v[3:0], 6'h00} : v});
		end
		prev_ok    = 1'b1;
		prev_chan  = chan;
		prev_right = right;
		n = 0;
		// Gap keeps the result load clear of the next frame
		while (((busy | busy4 | busy1) !== 1'b0 ||
			u_sami_if.status !== 1'b0) && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 400)
			failures++;
		repeat (30) @(negedge ref_clk);
	endtask

	task automatic do_reset;
		@(negedge ref_clk);
		reset       = 1'b1;
		prev_ok     = 1'b0;
		wire_frames = 0;
		repeat (3) @(negedge ref_clk);
		reset = 1'b0;
	endtask

	initial begin
		reset       = 1'b1;
		req         = 1'b0;
		req_chan    = 3'h0;
		req_right   = 1'b0;
		prev_ok     = 1'b0;
		prev_chan   = 3'h0;
		prev_right  = 1'b0;
		armed       = 1'b0;
		wire_sh     = 16'h0000;
		wire_bits   = 0;
		wire_frames = 0;
		failures    = 0;
		checked     = 0;
		void'($urandom(91));
		for (int i = 0; i < 8; i++)
			analog_input[i] = 10'($urandom);
		analog_input[0] = 10'h3FF;
		analog_input[7] = 10'h000;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		for (int i = 0; i < 8; i++)
			run_frame(3'(i), i[1]);
		for (int i = 0; i < 6; i++)
			run_frame(3'($urandom), 1'($urandom));
		do_reset();
		for (int i = 0; i < 3; i++)
			run_frame(3'($urandom), 1'($urandom));
		print_verdict();
	end

	initial begin
		#(sami_pkg::CLK_PERIOD_NS * 20000);
		failures++;
		print_verdict();
	end
endmodule
